// *** rtl/cpr_io_fabric.sv ***
// Purpose: Row and column routing, global inputs, peripheral bus and pin cells.
// Assumes: One column of logic array blocks; pins and dedicated inputs are asynchronous.
// Notes: Routing is sampled each cycle; pin cell flops fire on periph clock edges.
`timescale 1ns/1ps
`include "cpr_regs.svh"
// How it works
// RULE1: Each row owns 96 channels reaching its blocks and pin cells.
// RULE2: A macrocell drives one of its three column channels.
// RULE3: Column channels span the column, shared by its macrocells.
// RULE4: Four-input selector puts macrocell or column signal on a row channel.
// RULE5: With the macrocell on the row, three-input selector feeds another row channel.
// RULE6: All 48 column channels reach 32 row channels per block.
// RULE7: A row pin cell input drives two row channels.
// RULE8: A row pin cell output picks one of ten row channels.
// RULE9: Each row end serves eight pin cells.
// RULE10: Each column end serves ten cells; their input drives two channels.
// RULE11: A column pin cell output picks one of seventeen column channels.
// RULE12: Four dedicated inputs give global clocks, clear and output enable.
// RULE13: Dedicated inputs also feed row channels as data.
// RULE14: Each pin is input only, output only or bidirectional.
// RULE15: Each pin cell has one flop with clock enable, input or output.
// RULE16: Cell clock, enable, clear and output enable come from global or logic.
// RULE17: Peripheral bus: eight enables, four clocks, six clock enables, two clears.
// RULE18: Bus lines share: enables 0-4 with clock enables, OE7 with clear1, clear0.
// RULE19: Global clocks are true or inverted copies of either clock pin.
// RULE20: Global clear polarity is selectable.
// RULE21: Inactive output enable releases the pin driver.
module cpr_io_fabric #(
    parameter  int N_ROWS = 4,                                 // Block rows in the column.
    localparam int NMC    = N_ROWS * `CPR_MC_PER_LAB,          // Macrocells.
    localparam int NRC    = N_ROWS * 2 * `CPR_ROW_IO_END,      // Row pin cells.
    localparam int NC     = NRC + 2 * `CPR_COL_IO_END          // All pin cells.
) (
    input  wire logic                                      I_CLOCK,         // Clock, 250 MHz.
    input  wire logic                                      I_RESET_N,       // Async reset, low.
    input  wire logic [NMC-1:0]                            I_MACRO_OUT,     // Macrocell outputs.
    input  wire cpr_pkg::cpr_mc_cfg_s [NMC-1:0]            I_MC_CFG,        // Macrocell routing.
    input  wire cpr_pkg::cpr_cell_cfg_s [NC-1:0]           I_CELL_CFG,      // Pin cell setup.
    input  wire cpr_pkg::cpr_glob_cfg_s                    I_GLOBAL_CFG,    // Global line setup.
    input  wire logic [`CPR_N_PLOG-1:0][`CPR_PCH_W-1:0]    I_PERIPH_CHAN,   // Bus source channels.
    input  wire logic [`CPR_N_DED-1:0]                     I_DEDICATED,     // Dedicated pins.
    input  wire logic [NC-1:0]                             I_PIN,           // Pin levels in.
    output logic [NC-1:0]                                  O_PIN,           // Pin levels out.
    output logic [NC-1:0]                                  O_PIN_OE_N,      // Low while driving.
    output logic [N_ROWS-1:0][`CPR_ROW_CH-1:0]             O_ROW_CHAN,      // Row channels.
    output logic [`CPR_COL_CH-1:0]                         O_COL_CHAN,      // Column channels.
    output logic [1:0]                                     O_GLOBAL_CLOCK,  // Global clocks.
    output logic                                           O_GLOBAL_CLEAR   // Global clear, high.
);
    import cpr_pkg::*;

    // Source row of each logic driven bus line: enables 0-7, clear 0, clocks 2 and 3.
    localparam int SRC_ROW [`CPR_N_PLOG] = '{`CPR_ROW_C, `CPR_ROW_B, `CPR_ROW_A, `CPR_ROW_B,
        `CPR_ROW_A, `CPR_ROW_D, `CPR_ROW_C, `CPR_ROW_B, `CPR_ROW_A, `CPR_ROW_D, `CPR_ROW_C};

    // Rows up to D must exist for the bus sources.
    if (N_ROWS < 4) begin : g_chk
        $error("N_ROWS must be at least 4");
    end

    // Wraps a selected channel index into the channel range.
    function automatic int chan_idx(input int base, input int sel, input int nsel, input int nch);
        int t;
        t = base + ((sel < nsel) ? sel : 0);
        return (t >= nch) ? t - nch : t;
    endfunction

    logic [NC-1:0]                 pin_m_r;
    logic [NC-1:0]                 pin_s_r;
    logic [`CPR_N_DED-1:0]         ded_m_r;
    logic [`CPR_N_DED-1:0]         ded_s_r;
    logic [1:0]                    gclk_r;
    logic                          global_clear_line_r;
    logic                          goe_r;
    logic [`CPR_N_OE-1:0]          oe_r;
    logic [`CPR_N_CLK-1:0]         clk_r;
    logic [`CPR_N_CLK-1:0]         clk_q_r;
    logic                          clr0_r;
    logic [`CPR_N_CLR-1:0]         clr_line;
    logic [`CPR_N_CE-1:0]          ce_line;
    logic [7:0]                    ce_all;
    logic [3:0]                    clr_all;
    logic [N_ROWS-1:0][`CPR_ROW_CH-1:0] rch;
    logic [N_ROWS-1:0][`CPR_ROW_CH-1:0] row_chan_r;
    logic [`CPR_COL_CH-1:0]        col;
    logic [`CPR_COL_CH-1:0]        col_chan_r;
    logic [NC-1:0]                 cin;
    logic [NC-1:0]                 cout;
    logic [`CPR_N_PLOG-1:0]        plog;

    // Two flop synchronisers for every pin and dedicated input.
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
            ded_m_r <= '0;
            ded_s_r <= '0;
        end else begin
            pin_m_r <= I_PIN;
            pin_s_r <= pin_m_r;
            ded_m_r <= I_DEDICATED;
            ded_s_r <= ded_m_r;
        end
    end

    // Global clocks, clear and output enable from the dedicated inputs.
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            gclk_r <= '0;
            global_clear_line_r <= 1'b0;
            goe_r  <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                gclk_r[i] <= ded_s_r[I_GLOBAL_CFG.clk_pin[i]] ^ I_GLOBAL_CFG.clk_inv[i]; // [RULE19] [RULE12]
            end
            global_clear_line_r <= ded_s_r[`CPR_DED_CLR] ^ I_GLOBAL_CFG.clr_low; // [RULE20]
            goe_r  <= ded_s_r[`CPR_DED_OE]; // [RULE12]
        end
    end

    assign O_GLOBAL_CLOCK = gclk_r;
    assign O_GLOBAL_CLEAR = global_clear_line_r;

    // Peripheral bus lines, each taken from a row channel or a global line.
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            oe_r    <= '0;
            clk_r   <= '0;
            clk_q_r <= '0;
            clr0_r  <= 1'b0;
        end else begin
            oe_r[6:0] <= plog[6:0]; // [RULE17]
            oe_r[7]   <= I_GLOBAL_CFG.oe7_global ? goe_r : plog[7]; // [RULE16]
            clr0_r    <= I_GLOBAL_CFG.clr0_global ? global_clear_line_r : plog[8]; // [RULE16]
            clk_r     <= {plog[10], plog[9], gclk_r}; // [RULE18]
            clk_q_r   <= clk_r;
        end
    end

    // Shared bus lines: clock enables and the second clear reuse other lines.
    assign ce_line  = {clr0_r, oe_r[4:0]}; // [RULE18]
    assign clr_line = {oe_r[7], clr0_r}; // [RULE18]
    assign ce_all   = {2'b11, ce_line};
    assign clr_all  = {1'b0, clr_line, 1'b0};

    // Column and row channels, pin cell output selectors and bus sources.
    always_comb begin
        col  = '0;
        rch  = '0;
        cout = '0;
        plog = '0;
        for (int m = 0; m < NMC; m++) begin
            if (I_MC_CFG[m].col_drive && I_MC_CFG[m].col_sel < 2'd3) begin
                col[(m % `CPR_MC_PER_LAB) * `CPR_COL_PER_MC + int'(I_MC_CFG[m].col_sel)] |=
                    I_MACRO_OUT[m]; // [RULE2] [RULE3]
            end
        end
        for (int k = 0; k < 2 * `CPR_COL_IO_END; k++) begin
            col[2 * k]     |= cin[NRC + k]; // [RULE10]
            col[2 * k + 1] |= cin[NRC + k]; // [RULE10]
        end
        for (int m = 0; m < NMC; m++) begin
            if (I_MC_CFG[m].row_drive) begin
                rch[m / `CPR_MC_PER_LAB][2 * (m % `CPR_MC_PER_LAB)] = (I_MC_CFG[m].row_sel == 2'd0) ?
                    I_MACRO_OUT[m] :
                    col[(m % `CPR_MC_PER_LAB) * 3 + int'(I_MC_CFG[m].row_sel) - 1]; // [RULE4] [RULE6]
            end
            if (I_MC_CFG[m].row_drive && I_MC_CFG[m].row_sel == 2'd0 && I_MC_CFG[m].aux_sel != 2'd0) begin
                rch[m / `CPR_MC_PER_LAB][2 * (m % `CPR_MC_PER_LAB) + 1] =
                    col[(m % `CPR_MC_PER_LAB) * 3 + int'(I_MC_CFG[m].aux_sel) - 1]; // [RULE5] [RULE6]
            end
        end
        for (int k = 0; k < NRC; k++) begin
            rch[k / 16][`CPR_IO_CH_BASE + 2 * (k % 16)]     = cin[k]; // [RULE7]
            rch[k / 16][`CPR_IO_CH_BASE + 2 * (k % 16) + 1] = cin[k]; // [RULE7]
        end
        for (int r = 0; r < N_ROWS; r++) begin
            for (int d = 0; d < `CPR_N_DED; d++) begin
                rch[r][`CPR_DED_CH_BASE + d] = ded_s_r[d]; // [RULE13]
            end
        end
        for (int k = 0; k < NRC; k++) begin
            cout[k] = rch[k / 16][chan_idx((k % 16) * `CPR_ROW_STEP, int'(I_CELL_CFG[k].out_sel),
                `CPR_ROW_MUX, `CPR_ROW_CH)]; // [RULE8] [RULE9]
        end
        for (int k = 0; k < 2 * `CPR_COL_IO_END; k++) begin
            cout[NRC + k] = col[chan_idx(k * `CPR_COL_STEP, int'(I_CELL_CFG[NRC + k].out_sel),
                `CPR_COL_MUX, `CPR_COL_CH)]; // [RULE11]
        end
        for (int i = 0; i < `CPR_N_PLOG; i++) begin
            plog[i] = rch[SRC_ROW[i]][chan_idx(0, int'(I_PERIPH_CHAN[i]), `CPR_ROW_CH, `CPR_ROW_CH)]; // [RULE16]
        end
    end

    // Channel snapshots handed to the blocks in each row and column.
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            row_chan_r <= '0;
            col_chan_r <= '0;
        end else begin
            row_chan_r <= rch; // [RULE1]
            col_chan_r <= col; // [RULE3]
        end
    end

    assign O_ROW_CHAN = row_chan_r;
    assign O_COL_CHAN = col_chan_r;

    // One pin cell per pin: selectable flop, input path and output driver.
    for (genvar k = 0; k < NC; k++) begin : g_cell
        cpr_cell_cfg_s c;
        logic          clk_edge;
        logic          q_r;
        logic          pin_r;
        logic          oe_n_r;
        assign c        = I_CELL_CFG[k];
        assign clk_edge = clk_r[c.clk_sel] & ~clk_q_r[c.clk_sel];

        // The cell flop captures on a bus clock edge when enabled; clear overrides.
        always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
                q_r <= `CPR_CELL_RST;
            end else if (clr_all[c.clr_sel]) begin
                q_r <= `CPR_CELL_RST; // [RULE16]
            end else if (clk_edge && ce_all[c.ce_sel] && c.reg_mode != CPR_REG_NONE) begin
                q_r <= (c.reg_mode == CPR_REG_IN) ? pin_s_r[k] : cout[k]; // [RULE15]
            end
        end

        // Output only cells feed no channel.
        assign cin[k] = (c.mode == CPR_OUT_ONLY) ? 1'b0 : ((c.reg_mode == CPR_REG_IN) ? q_r : pin_s_r[k]); // [RULE14]

        // Driver level and enable; bidirectional cells follow their bus enable.
        always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
                pin_r  <= 1'b0;
                oe_n_r <= 1'b1;
            end else begin
                pin_r  <= (c.reg_mode == CPR_REG_OUT) ? q_r : cout[k]; // [RULE15]
                oe_n_r <= (c.mode == CPR_OUT_ONLY) ? 1'b0 :
                          (c.mode == CPR_BIDIR) ? ~oe_r[c.oe_sel] : 1'b1; // [RULE14] [RULE21]
            end
        end

        assign O_PIN[k]      = pin_r;
        assign O_PIN_OE_N[k] = oe_n_r;
    end

    // Checks on cell 0, macrocell 0 and the global lines.
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);

    logic oe_pick0;
    assign oe_pick0 = oe_r[I_CELL_CFG[0].oe_sel];

    in_only_oe_a: assert property (I_CELL_CFG[0].mode == CPR_IN_ONLY |=> O_PIN_OE_N[0]) // [RULE14]
        else $error("input only pin was driven");
    out_only_oe_a: assert property (I_CELL_CFG[0].mode == CPR_OUT_ONLY |=> !O_PIN_OE_N[0]) // [RULE14]
        else $error("output only pin was not driven");
    bidir_oe_a: assert property (I_CELL_CFG[0].mode == CPR_BIDIR |=> O_PIN_OE_N[0] == !$past(oe_pick0)) // [RULE21]
        else $error("bidirectional enable mismatch");
    global_clock_a: assert property (($stable(I_GLOBAL_CFG) [*3]) ##0 (I_GLOBAL_CFG.clk_pin[0] && // [RULE19]
        I_GLOBAL_CFG.clk_inv[0]) |-> O_GLOBAL_CLOCK[0] == !$past(I_DEDICATED[1], 3))
        else $error("global clock not inverted second pin");
    clear_polarity_a: assert property (($stable(I_GLOBAL_CFG) [*3]) |-> // [RULE20]
        O_GLOBAL_CLEAR == ($past(I_DEDICATED[2], 3) ^ I_GLOBAL_CFG.clr_low))
        else $error("global clear polarity wrong");
    clear_share_a: assert property (I_CELL_CFG[0].clr_sel == 2'd2 && oe_r[7] |=> !g_cell[0].q_r) // [RULE18]
        else $error("enable seven did not clear cell");
    row_macro_a: assert property (I_MC_CFG[0].row_drive && I_MC_CFG[0].row_sel == 2'd0 |=> // [RULE4]
        O_ROW_CHAN[0][0] == $past(I_MACRO_OUT[0]))
        else $error("macrocell not on row channel");
    aux_path_a: assert property (I_MC_CFG[0].row_drive && I_MC_CFG[0].row_sel == 2'd0 && // [RULE5]
        I_MC_CFG[0].aux_sel == 2'd1 |=> O_ROW_CHAN[0][1] == O_COL_CHAN[0])
        else $error("column to row path missing");
    col_drive_a: assert property (I_MC_CFG[0].col_drive && I_MC_CFG[0].col_sel == 2'd1 && // [RULE2]
        I_MACRO_OUT[0] |=> O_COL_CHAN[1])
        else $error("column channel not driven");
    dedicated_row_a: assert property (O_ROW_CHAN[0][`CPR_DED_CH_BASE] == $past(I_DEDICATED[0], 3)) // [RULE13]
        else $error("dedicated input not on row");
    cell_capture_a: assert property (I_CELL_CFG[0].reg_mode == CPR_REG_IN && I_CELL_CFG[0].ce_sel == 3'd7 && // [RULE15]
        I_CELL_CFG[0].clr_sel == 2'd0 && g_cell[0].clk_edge |=> g_cell[0].q_r == $past(pin_s_r[0]))
        else $error("cell flop missed capture");

    // The cell flop must hold between bus clock edges, or gated clocking would leak data.
    // Bus clocks 0 and 1 follow the global clocks; pin inputs land on both of their channels.
    cell_hold_a: assert property (!clr_all[I_CELL_CFG[0].clr_sel] && !g_cell[0].clk_edge |=> // [RULE15]
        $stable(g_cell[0].q_r))
        else $error("cell flop changed without edge");
    periph_clock_a: assert property (clk_r[1:0] == $past(O_GLOBAL_CLOCK)) // [RULE18]
        else $error("bus clocks not from global clocks");
    row_input_a: assert property (O_ROW_CHAN[0][`CPR_IO_CH_BASE + 1] == $past(cin[0])) // [RULE7]
        else $error("row pin input missing on second channel");
    col_input_a: assert property (cin[NRC] |=> O_COL_CHAN[0] && O_COL_CHAN[1]) // [RULE10]
        else $error("column pin input missing on channels");

    // Scenarios worth seeing: drive and release, column to row path, capture and shared clear.

    bidir_drive_c: cover property (I_CELL_CFG[0].mode == CPR_BIDIR ##1 !O_PIN_OE_N[0]);
    aux_used_c: cover property (I_MC_CFG[0].row_drive && I_MC_CFG[0].aux_sel != 2'd0 ##1 O_ROW_CHAN[0][1]);
    capture_c: cover property (g_cell[0].clk_edge && I_CELL_CFG[0].reg_mode != CPR_REG_NONE);
    clear_c: cover property (I_CELL_CFG[0].clr_sel == 2'd2 && oe_r[7] ##1 !g_cell[0].q_r);
    bidir_release_c: cover property (I_CELL_CFG[0].mode == CPR_BIDIR ##1 O_PIN_OE_N[0]);
endmodule

// *** rtl/cpr_regs.svh ***
// Purpose: Constants of the I/O cell and routing fabric.
// Assumes: Included by the package and by the fabric module.
// Notes: Channel counts, selector sizes and peripheral source rows.
`ifndef CPR_REGS_SVH
`define CPR_REGS_SVH
`define CPR_ROW_CH      96
`define CPR_COL_CH      48
`define CPR_MC_PER_LAB  16
`define CPR_COL_PER_MC  3
`define CPR_ROW_IO_END  8
`define CPR_COL_IO_END  10
`define CPR_ROW_MUX     10
`define CPR_COL_MUX     17
`define CPR_ROW_STEP    6
`define CPR_COL_STEP    2
`define CPR_IO_CH_BASE  32
`define CPR_DED_CH_BASE 64
`define CPR_N_DED       4
`define CPR_DED_CLR     2
`define CPR_DED_OE      3
`define CPR_N_OE        8
`define CPR_N_CLK       4
`define CPR_N_CE        6
`define CPR_N_CLR       2
`define CPR_N_PLOG      11
`define CPR_PCH_W       7
`define CPR_ROW_A       0
`define CPR_ROW_B       1
`define CPR_ROW_C       2
`define CPR_ROW_D       3
`define CPR_CELL_RST    1'b0
`endif

// *** rtl/cpr_pkg.sv ***
// Purpose: Types of the I/O cell and routing fabric.
// Assumes: cpr_regs.svh holds the constants.
// Notes: Configuration travels as packed structs.
`include "cpr_regs.svh"
package cpr_pkg;
    typedef enum logic [1:0] {CPR_IN_ONLY, CPR_OUT_ONLY, CPR_BIDIR} cpr_mode_e;
    typedef enum logic [1:0] {CPR_REG_NONE, CPR_REG_IN, CPR_REG_OUT} cpr_reg_e;
    typedef struct packed {
        cpr_mode_e  mode;
        cpr_reg_e   reg_mode;
        logic [1:0] clk_sel;
        logic [2:0] ce_sel;
        logic [1:0] clr_sel;
        logic [2:0] oe_sel;
        logic [4:0] out_sel;
    } cpr_cell_cfg_s;
    typedef struct packed {
        logic       col_drive;
        logic [1:0] col_sel;
        logic       row_drive;
        logic [1:0] row_sel;
        logic [1:0] aux_sel;
    } cpr_mc_cfg_s;
    typedef struct packed {
        logic [1:0] clk_pin;
        logic [1:0] clk_inv;
        logic       clr_low;
        logic       oe7_global;
        logic       clr0_global;
    } cpr_glob_cfg_s;
endpackage

// *** tb/cpr_pin_board.sv ***
// Purpose: Board circuits at the device pins.
// Assumes: One board driver per pin; the device output enable is low while it drives.
// Notes: A pin released by both sides floats up to 1 through a pull-up.
`timescale 1ns/1ps
module cpr_pin_board #(
    parameter int NC = 84                     // Pin count.
) (
    input  wire logic [NC-1:0] i_pin,         // Device drive level.
    input  wire logic [NC-1:0] i_pin_oe_n,    // Low while the device drives.
    input  wire logic [NC-1:0] i_drv_en,      // Board drives the pin.
    input  wire logic [NC-1:0] i_drv_val,     // Board drive level.
    output logic      [NC-1:0] o_wire         // Resolved pin level.
);
    // The device wins while it drives; a released pin shows the board or the pull-up.
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            o_wire[i] = !i_pin_oe_n[i] ? i_pin[i] : (i_drv_en[i] ? i_drv_val[i] : 1'b1);
        end
    end
endmodule

// *** tb/tb_cpr_io_fabric.sv ***
// Purpose: Self-checking bench of the routing and pin cell fabric.
// Assumes: Four block rows; board pins modelled by cpr_pin_board.
// Notes: Routing is checked cycle-exact, pin paths after a fixed settle time.
`timescale 1ns/1ps
module tb_cpr_io_fabric;
    import cpr_pkg::*;
    localparam int NMC = 64;
    localparam int NRC = 64;
    localparam int NC  = 84;
    localparam cpr_mc_cfg_s MC_DEF = '{col_drive:1'b1, col_sel:2'h0, row_drive:1'b1, row_sel:2'h0, aux_sel:2'h0};
    localparam cpr_cell_cfg_s CELL_IN = '{mode:CPR_IN_ONLY, reg_mode:CPR_REG_NONE, clk_sel:2'h0, ce_sel:3'h6,
                                          clr_sel:2'h0, oe_sel:3'h0, out_sel:5'h00};
    logic                    clk;
    logic                    rst_n;
    logic [NMC-1:0]          macro;
    cpr_mc_cfg_s [NMC-1:0]   mc_cfg;
    cpr_cell_cfg_s [NC-1:0]  cell_cfg;
    cpr_glob_cfg_s           gcfg;
    logic [10:0][6:0]        pch;
    logic [3:0]              ded;
    logic [NC-1:0]           pin_in, pin_out, pin_oe_n, drv_en, drv_val;
    logic [3:0][95:0]        row_ch;
    logic [47:0]             col_ch;
    logic [1:0]              gclk;
    logic                    global_clear_line;
    int                      errors, comparisons, seed;

    cpr_io_fabric #(.N_ROWS(4)) u_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_MACRO_OUT(macro), .I_MC_CFG(mc_cfg),
        .I_CELL_CFG(cell_cfg), .I_GLOBAL_CFG(gcfg), .I_PERIPH_CHAN(pch), .I_DEDICATED(ded), .I_PIN(pin_in),
        .O_PIN(pin_out), .O_PIN_OE_N(pin_oe_n), .O_ROW_CHAN(row_ch), .O_COL_CHAN(col_ch),
        .O_GLOBAL_CLOCK(gclk), .O_GLOBAL_CLEAR(global_clear_line));
    cpr_pin_board #(.NC(NC)) u_board (.i_pin(pin_out), .i_pin_oe_n(pin_oe_n), .i_drv_en(drv_en),
        .i_drv_val(drv_val), .o_wire(pin_in));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Level a pin cell feeds to its channels; output only cells feed nothing.
    function automatic logic cell_in(input int k);
        return (cell_cfg[k].mode == CPR_OUT_ONLY) ? 1'b0 : pin_in[k];
    endfunction

    // Expected column channels: macrocell drives ORed with column pin inputs.
    function automatic logic [47:0] exp_col();
        logic [47:0] e;
        e = '0;
        for (int m = 0; m < NMC; m++) begin
            if (mc_cfg[m].col_drive && mc_cfg[m].col_sel < 3) e[3*(m%16)+mc_cfg[m].col_sel] |= macro[m];
        end
        for (int k = 0; k < 20; k++) begin
            e[2*k]   |= cell_in(NRC+k);
            e[2*k+1] |= cell_in(NRC+k);
        end
        return e;
    endfunction

    // Expected row channels of row r.
    function automatic logic [95:0] exp_row(input int r);
        logic [95:0] e;
        logic [47:0] c;
        cpr_mc_cfg_s q;
        e = '0;
        c = exp_col();
        for (int j = 0; j < 16; j++) begin
            q = mc_cfg[16*r+j];
            e[2*j] = (q.row_sel == 0) ? macro[16*r+j] : c[3*j+q.row_sel-1];
            if (q.row_sel == 0 && q.aux_sel != 0) e[2*j+1] = c[3*j+q.aux_sel-1];
            e[32+2*j] = cell_in(16*r+j);
            e[33+2*j] = cell_in(16*r+j);
        end
        e[67:64] = ded;
        return e;
    endfunction

    // Checks every row and the column channels against the model.
    task automatic check_fabric();
        for (int r = 0; r < 4; r++) chk("row_chan", exp_row(r), row_ch[r]);
        chk("col_chan", exp_col(), col_ch);
    endtask

    // Main sequence.
    initial begin
        cpr_cell_cfg_s cc;
        logic [95:0]   rv;
        logic [47:0]   cv;
        int            j;
        seed = 32'h82d7f17f;
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        macro = '0;
        mc_cfg = {NMC{MC_DEF}};
        cell_cfg = {NC{CELL_IN}};
        gcfg = '0;
        pch = {11{7'd90}};
        ded = 4'h0;
        drv_en = '1;
        drv_val = '0;
        repeat (16) @(posedge clk);
        #1;
        chk("pin_oe_n", {NC{1'b1}}, pin_oe_n);
        chk("row_chan", 96'h0, row_ch[0]);
        @(posedge clk);
        rst_n <= 1'b1;
        // Random macrocell traffic with cycle-exact routing checks.
        for (int it = 0; it < 40; it++) begin
            @(posedge clk);
            macro <= (it == 0) ? '1 : {$random(seed), $random(seed)};
            for (int m = 0; m < NMC; m++) mc_cfg[m].col_sel <= 2'(($random(seed) & 3) % 3);
            @(posedge clk);
            #1;
            check_fabric();
        end
        // Column-to-row selectors, pin inputs, dedicated inputs and global line setup.
        for (int it = 0; it < 32; it++) begin
            @(posedge clk);
            macro <= {$random(seed), $random(seed)};
            ded <= 4'($random(seed));
            drv_val <= NC'({$random(seed), $random(seed), $random(seed)});
            gcfg <= '{clk_pin:it[1:0], clk_inv:it[3:2], clr_low:it[4], oe7_global:1'b0, clr0_global:1'b0};
            for (int m = 0; m < NMC; m++) begin
                mc_cfg[m].row_sel <= 2'($random(seed));
                mc_cfg[m].aux_sel <= 2'($random(seed));
            end
            repeat (6) @(posedge clk);
            #1;
            check_fabric();
            for (int i = 0; i < 2; i++) chk("global_clock", ded[gcfg.clk_pin[i]] ^ gcfg.clk_inv[i], gclk[i]);
            chk("global_clear", ded[2] ^ gcfg.clr_low, global_clear_line);
        end
        // Output, bidirectional and input cells; enable line 0 taken from dedicated input 1.
        @(posedge clk);
        pch[0] <= 7'd65;
        mc_cfg <= {NMC{MC_DEF}};
        for (int c = 0; c < NC; c++) begin
            cc = CELL_IN;
            j = c % 16;
            if (c < NRC && ((j > 0 && j < 5) || j > 10)) begin
                cc.mode = CPR_OUT_ONLY;
                cc.out_sel = 5'($unsigned($random(seed)) % 6);
            end else if (c < NRC) begin
                cc.mode = CPR_BIDIR;
            end else if (c >= NRC + 16) begin
                cc.mode = CPR_OUT_ONLY;
                cc.out_sel = 5'(40 - 2 * (c - NRC) + $unsigned($random(seed)) % 8);
            end
            cell_cfg[c] <= cc;
        end
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            macro <= {$random(seed), $random(seed)};
            ded <= {2'b00, b[0], 1'b0};
            repeat (8) @(posedge clk);
            #1;
            cv = exp_col();
            for (int c = 0; c < NC; c++) begin
                rv = exp_row(c / 16);
                if (cell_cfg[c].mode == CPR_OUT_ONLY && c < NRC) begin
                    chk("row_pin_out", rv[(6 * (c % 16) + cell_cfg[c].out_sel) % 96], pin_out[c]);
                end else if (cell_cfg[c].mode == CPR_OUT_ONLY) begin
                    chk("col_pin_out", cv[(2 * (c - NRC) + cell_cfg[c].out_sel) % 48], pin_out[c]);
                end
                chk("pin_oe_n", (cell_cfg[c].mode == CPR_OUT_ONLY) ? 1'b0 :
                    (cell_cfg[c].mode == CPR_BIDIR) ? !b[0] : 1'b1, pin_oe_n[c]);
            end
        end
        // Input register of cell 0 clocked by global clock 0 from dedicated input 0.
        @(posedge clk);
        cc = CELL_IN;
        cc.reg_mode = CPR_REG_IN;
        cc.ce_sel = 3'h7;
        cell_cfg[0] <= cc;
        gcfg <= '0;
        ded <= 4'h0;
        drv_val[0] <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("cell_reg_idle", 1'b0, row_ch[0][32]);
        @(posedge clk);
        ded <= 4'h1;
        j = 0;
        while (gclk[0] !== 1'b1) begin
            @(posedge clk);
            #1;
            j++;
            if (j > 10) begin
                errors++;
                $display("[FAIL] global_clock_wait expected 1 seen %b", gclk[0]);
                give_verdict();
            end
        end
        repeat (4) @(posedge clk);
        #1;
        chk("cell_reg_capture", 1'b1, row_ch[0][32]);
        @(posedge clk);
        drv_val[0] <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("cell_reg_hold", 1'b1, row_ch[0][32]);
        // Enable line 7 from row B channel 65 doubles as clear 1 and empties cell 0.
        @(posedge clk);
        cc.clr_sel = 2'h2;
        cell_cfg[0] <= cc;
        pch[7] <= 7'd65;
        ded <= 4'h3;
        repeat (8) @(posedge clk);
        #1;
        chk("cell_reg_clear", 1'b0, row_ch[0][32]);
        give_verdict();
    end
endmodule
